/* hw/cec_top.sv */
// Cascaded 24-bit external event counter with gating timer
`timescale 1ns/1ps
module cec_top (
    input  wire logic                    clock,
    input  wire logic                    nrst,
    input  wire logic                    lower_event_input,
    input  wire cec_pkg::cec_upper_cfg_s upper_cfg,
    input  wire cec_pkg::cec_lower_cfg_s lower_cfg,
    input  wire logic                    lower_match_flag_clear,
    output cec_pkg::cec_events_s         events_ff,
    output logic [15:0]                  upper_counter_ff,
    output logic [7:0]                   lower_counter_ff,
    output logic [7:0]                   gating_timer_ff,
    output logic                         gate_output_ff,
    output logic                         lower_match_flag_ff,
    output logic                         timer_output_pin_ff
);
    logic       ev_q;
    logic       ev_rise;
    logic       ev_fall;
    logic       ev_edge;
    logic       gate_sampled_ff;
    logic       lower_match;
    logic       upper_tick;
    logic       upper_run;
    logic       upper_armed_ff;
    logic       upper_match;
    logic       sec_match;
    logic       gating_started_ff;
    logic       gate_period_hit;
    logic       gate_duty_hit;
    logic       nxt_gate;

    // Event pin synchronised into the clock domain
    cec_sync u_event_sync (
        .clock (clock),
        .nrst  (nrst),
        .d     (lower_event_input),
        .q     (ev_q),
        .rise  (ev_rise),
        .fall  (ev_fall)
    );

    // Selected edge of the event input
    always_comb begin
        case (lower_cfg.lower_edge_select)
            cec_pkg::EDGE_FALL: ev_edge = ev_fall;
            cec_pkg::EDGE_RISE: ev_edge = ev_rise;
            default:            ev_edge = 1'b0;
        endcase
    end

    // Gate level captured at each event edge
    always_ff @(posedge clock) begin
        if (!nrst) begin
            gate_sampled_ff <= 1'b1;
        end else if (ev_edge) begin
            gate_sampled_ff <= gate_output_ff;
        end
    end

    // Lower counter with compare clear
    assign lower_match = lower_cfg.lower_run_enable & ev_edge
                       & (~lower_cfg.input_gate_select | gate_sampled_ff)
                       & (lower_counter_ff == lower_cfg.lower_compare);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            lower_counter_ff <= cec_pkg::LOWER_RESET;
        end else if (!lower_cfg.lower_run_enable) begin
            lower_counter_ff <= cec_pkg::LOWER_RESET;
        end else if (ev_edge &&
                     (!lower_cfg.input_gate_select || gate_sampled_ff)) begin
            if (lower_match) begin
                lower_counter_ff <= cec_pkg::LOWER_RESET;
            end else begin
                lower_counter_ff <= lower_counter_ff + 8'h01;
            end
        end
    end

    // Lower match flag, set wins over clear
    always_ff @(posedge clock) begin
        if (!nrst) begin
            lower_match_flag_ff <= 1'b0;
        end else if (lower_match) begin
            lower_match_flag_ff <= 1'b1;
        end else if (lower_match_flag_clear) begin
            lower_match_flag_ff <= 1'b0;
        end
    end

    // Upper counter clocked by lower match, first tick dropped
    assign upper_run   = upper_cfg.mode != cec_pkg::MODE_STOP;
    assign upper_tick  = upper_run & lower_match;
    assign upper_match = upper_tick & upper_armed_ff
                       & (upper_counter_ff == upper_cfg.main_compare);
    assign sec_match   = upper_tick & upper_armed_ff
                       & (upper_counter_ff == upper_cfg.secondary_compare);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            upper_armed_ff <= 1'b0;
        end else if (!upper_run) begin
            upper_armed_ff <= 1'b0;
        end else if (upper_tick) begin
            upper_armed_ff <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            upper_counter_ff <= cec_pkg::UPPER_RESET;
        end else if (!upper_run) begin
            upper_counter_ff <= cec_pkg::UPPER_RESET;
        end else if (upper_tick && upper_armed_ff) begin
            if (upper_counter_ff == upper_cfg.main_compare) begin
                upper_counter_ff <= cec_pkg::UPPER_RESET;
            end else begin
                upper_counter_ff <= upper_counter_ff + 16'h0001;
            end
        end
    end

    // Gating timer in duty mode
    assign gate_period_hit = lower_cfg.gating_run_enable
                           & (gating_timer_ff ==
                              lower_cfg.gating_period_compare);
    assign gate_duty_hit   = lower_cfg.gating_run_enable & gating_started_ff
                           & (gating_timer_ff ==
                              lower_cfg.gating_duty_compare);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            gating_timer_ff <= cec_pkg::GATE_RESET;
        end else if (!lower_cfg.gating_run_enable || gate_period_hit) begin
            gating_timer_ff <= cec_pkg::GATE_RESET;
        end else begin
            gating_timer_ff <= gating_timer_ff + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            gating_started_ff <= 1'b0;
        end else if (!lower_cfg.gating_run_enable) begin
            gating_started_ff <= 1'b0;
        end else if (gate_period_hit) begin
            gating_started_ff <= 1'b1;
        end
    end

    // Gate level: default until first period match, then duty pattern
    always_comb begin
        nxt_gate = gate_output_ff;
        if (!lower_cfg.gating_run_enable) begin
            nxt_gate = lower_cfg.gating_output_default_level;
        end else if (gate_period_hit) begin
            nxt_gate = ~lower_cfg.gating_output_default_level;
        end else if (gate_duty_hit) begin
            nxt_gate = lower_cfg.gating_output_default_level;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            gate_output_ff <= 1'b1;
        end else begin
            gate_output_ff <= nxt_gate;
        end
    end

    // Event pulses, one cycle each
    always_ff @(posedge clock) begin
        if (!nrst) begin
            events_ff <= '0;
        end else begin
            events_ff.main_match_interrupt      <= upper_match;
            events_ff.secondary_match_interrupt <= sec_match;
            events_ff.lower_match_interrupt     <= lower_match;
            events_ff.gating_interrupt          <= gate_period_hit;
        end
    end

    // Timer output: preset while stopped, toggle while running
    always_ff @(posedge clock) begin
        if (!nrst) begin
            timer_output_pin_ff <= 1'b0;
        end else if (!upper_run) begin
            case (upper_cfg.preset)
                cec_pkg::PRESET_LOW:  timer_output_pin_ff <= 1'b0;
                cec_pkg::PRESET_HIGH: timer_output_pin_ff <= 1'b1;
                default: begin
                    timer_output_pin_ff <= timer_output_pin_ff;
                end
            endcase
        end else if ((upper_match && upper_cfg.main_toggle_enable) !=
                     (sec_match && upper_cfg.secondary_toggle_enable)) begin
            timer_output_pin_ff <= ~timer_output_pin_ff;
        end
    end
endmodule

/* hw/cec_pkg.sv */
// Package with constants and carrier structs of the cascaded event counter
package cec_pkg;
    localparam logic [1:0]  MODE_STOP      = 2'h0;
    localparam logic [1:0]  MODE_CLR_MATCH = 2'h3;
    localparam logic [1:0]  EDGE_FALL      = 2'h0;
    localparam logic [1:0]  EDGE_RISE      = 2'h1;
    localparam logic [1:0]  PRESET_NONE    = 2'h0;
    localparam logic [1:0]  PRESET_LOW     = 2'h1;
    localparam logic [1:0]  PRESET_HIGH    = 2'h2;
    localparam logic [7:0]  LOWER_RESET    = 8'h00;
    localparam logic [15:0] UPPER_RESET    = 16'h0000;
    localparam logic [7:0]  GATE_RESET     = 8'h00;
    localparam int          SYNC_STAGES    = 2;

    // Upper counter configuration
    typedef struct packed {
        logic [1:0]  mode;
        logic [15:0] main_compare;
        logic [15:0] secondary_compare;
        logic        main_toggle_enable;
        logic        secondary_toggle_enable;
        logic [1:0]  preset;
    } cec_upper_cfg_s;

    // Lower and gating configuration
    typedef struct packed {
        logic        lower_run_enable;
        logic [1:0]  lower_edge_select;
        logic [7:0]  lower_compare;
        logic        gating_run_enable;
        logic        gating_output_default_level;
        logic [7:0]  gating_period_compare;
        logic [7:0]  gating_duty_compare;
        logic        input_gate_select;
    } cec_lower_cfg_s;

    // Event pulses out of the block
    typedef struct packed {
        logic main_match_interrupt;
        logic secondary_match_interrupt;
        logic lower_match_interrupt;
        logic gating_interrupt;
    } cec_events_s;
endpackage

/* hw/cec_sync.sv */
// Two-stage level synchroniser with edge detect on the settled stage
`timescale 1ns/1ps
module cec_sync (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic d,
    output logic      q,
    output logic      rise,
    output logic      fall
);
    logic [cec_pkg::SYNC_STAGES-1:0] stage_ff;
    logic                            last_ff;

    // First stage is read only by the second
    always_ff @(posedge clock) begin
        if (!nrst) begin
            stage_ff <= '0;
            last_ff  <= 1'b0;
        end else begin
            stage_ff <= {stage_ff[cec_pkg::SYNC_STAGES-2:0], d};
            last_ff  <= stage_ff[cec_pkg::SYNC_STAGES-1];
        end
    end

    assign q    = stage_ff[cec_pkg::SYNC_STAGES-1];
    assign rise = q & ~last_ff;
    assign fall = ~q & last_ff;
endmodule

/* tb/cec_monitor.sv */
// Port checker of the cascaded event counter
`timescale 1ns/1ps
module cec_monitor (
    input wire logic                    clock,
    input wire logic                    nrst,
    input wire cec_pkg::cec_upper_cfg_s upper_cfg,
    input wire cec_pkg::cec_lower_cfg_s lower_cfg,
    input wire cec_pkg::cec_events_s    events_ff,
    input wire logic [15:0]             upper_counter_ff,
    input wire logic [7:0]              lower_counter_ff,
    input wire logic                    gate_output_ff,
    input wire logic                    lower_match_flag_ff,
    input wire logic                    timer_output_pin_ff
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // Upper counter stopped
    wire logic stp = upper_cfg.mode == cec_pkg::MODE_STOP;
    // Upper count at its compare value, then a lower wrap
    sequence s_at_top;
        !stp && upper_counter_ff == upper_cfg.main_compare
        ##1 events_ff.lower_match_interrupt;
    endsequence
    a_lower_wrap: assert property (events_ff.lower_match_interrupt |->
        lower_counter_ff == 8'h00 && lower_match_flag_ff) else $error("wrap");
    a_upper_wrap: assert property (s_at_top |->
        events_ff.main_match_interrupt && upper_counter_ff == 16'h0000)
        else $error("upper wrap");
    a_upper_cause: assert property (!$past(stp) &&
        $changed(upper_counter_ff) |-> events_ff.lower_match_interrupt)
        else $error("upper step");
    a_second_tick: assert property (events_ff.secondary_match_interrupt
        |-> events_ff.lower_match_interrupt) else $error("second match");
    a_gate_int_low: assert property (events_ff.gating_interrupt &&
        lower_cfg.gating_output_default_level |-> !gate_output_ff)
        else $error("gate level");
    a_gate_open: assert property ($rose(lower_cfg.gating_run_enable) &&
        lower_cfg.gating_period_compare > 8'h08 |-> gate_output_ff[*8])
        else $error("gate open");
    a_preset_set: assert property (stp && upper_cfg.preset[0] !=
        upper_cfg.preset[1] |=>
        timer_output_pin_ff == $past(upper_cfg.preset[1]))
        else $error("preset");
    a_preset_keep: assert property (stp && upper_cfg.preset == 2'h0
        |=> $stable(timer_output_pin_ff)) else $error("preset hold");
    a_pin_toggle: assert property (events_ff.main_match_interrupt &&
        $past(upper_cfg.main_toggle_enable) && !$past(stp) &&
        !(events_ff.secondary_match_interrupt &&
          $past(upper_cfg.secondary_toggle_enable))
        |-> $changed(timer_output_pin_ff))
        else $error("toggle");
endmodule
bind cec_top cec_monitor mon (.clock, .nrst, .upper_cfg, .lower_cfg,
    .events_ff, .upper_counter_ff, .lower_counter_ff, .gate_output_ff,
    .lower_match_flag_ff, .timer_output_pin_ff);

/* tb/cec_src.sv */
// Event pulse source at the lower counter input pin
`timescale 1ns/1ps
module cec_src (
    input  wire logic       clock,
    input  wire logic       start,
    input  wire logic [8:0] count,
    output logic            pin,
    output logic            busy
);
    integer seed = 19352;
    // Bursts of pulses, each level held two to five clocks
    initial begin
        pin = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clock);
            if (start) begin
                busy <= 1'b1;
                for (int i = 0; i < count; i++) begin
                    pin <= 1'b1;
                    repeat (2 + ($random(seed) & 3)) @(posedge clock);
                    pin <= 1'b0;
                    repeat (2 + ($random(seed) & 3)) @(posedge clock);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

/* tb/test_cascaded_event_counter_24bit.sv */
// Self-checking bench of the cascaded event counter
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module test_cascaded_event_counter_24bit;
    logic                    clock = 1'b0, nrst = 1'b0, clr = 1'b0;
    logic                    start = 1'b0, busy, flag, pin, pin_in, gate;
    cec_pkg::cec_upper_cfg_s ucfg = '0;
    cec_pkg::cec_lower_cfg_s lcfg = '0;
    cec_pkg::cec_events_s    ev;
    logic [15:0]             up;
    logic [7:0]              lo, base, gt;
    logic [8:0]              cnt = '0;
    logic [25:0]             exp_q[$], e;
    logic [1:0]              pv[5] = '{2'h2, 2'h0, 2'h1, 2'h2, 2'h0};
    logic [4:0]              pe = 5'h1b;
    int                      err_total = 0, check_count = 0;
    cec_top dut (.clock, .nrst, .lower_event_input(pin_in), .upper_cfg(ucfg),
        .lower_cfg(lcfg), .lower_match_flag_clear(clr), .events_ff(ev),
        .upper_counter_ff(up), .lower_counter_ff(lo), .gating_timer_ff(gt),
        .gate_output_ff(gate), .lower_match_flag_ff(flag),
        .timer_output_pin_ff(pin));
    cec_src src (.clock, .start, .count(cnt), .pin(pin_in), .busy);
    // Clock of 50 ns period
    always #25 clock = ~clock;
    // Each lower wrap against the oldest noted result
    always @(posedge clock) begin
        if (nrst && ev.lower_match_interrupt === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            `CHK({ev.main_match_interrupt, up, lo, flag}, e)
        end
    end
    function automatic void note(logic m, logic [15:0] u);
        exp_q.push_back({m, u, 8'h00, 1'b1});
    endfunction
    task automatic burst(input logic [8:0] n);
        cnt <= n;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        @(posedge clock);
        while (busy) @(posedge clock);
        repeat (4) @(posedge clock);
    endtask
    task automatic stop_test();
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (40000) @(posedge clock);
        err_total++;
        stop_test();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            ucfg.preset <= pv[i];
            repeat (2) @(posedge clock);
            `CHK(pin, pe[i])
        end
        ucfg.main_compare <= 16'h0002;
        ucfg.secondary_compare <= 16'h0001;
        lcfg.lower_compare <= 8'hff;
        lcfg.lower_edge_select <= cec_pkg::EDGE_RISE;
        lcfg.gating_output_default_level <= 1'b1;
        ucfg.main_toggle_enable <= 1'b0;
        @(posedge clock);
        ucfg.mode <= cec_pkg::MODE_CLR_MATCH;
        @(posedge clock);
        lcfg.lower_run_enable <= 1'b1;
        `CHK(pin, 1'b1)
        note(1'b0, 16'h0000);
        note(1'b0, 16'h0001);
        note(1'b0, 16'h0002);
        note(1'b1, 16'h0000);
        repeat (4) burst(9'h100);
        `CHK({up + {15'h0, flag}, lo}, 24'h000100)
        lcfg.lower_run_enable <= 1'b0;
        lcfg.lower_edge_select <= cec_pkg::EDGE_FALL;
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        lcfg.lower_run_enable <= 1'b1;
        burst(9'h005);
        `CHK({lo, flag}, 9'h0a)
        lcfg.lower_run_enable <= 1'b0;
        lcfg.input_gate_select <= 1'b1;
        lcfg.gating_output_default_level <= 1'b1;
        lcfg.gating_period_compare <= 8'hff;
        lcfg.gating_duty_compare <= 8'hfe;
        @(posedge clock);
        lcfg.lower_run_enable <= 1'b1;
        @(posedge clock);
        lcfg.gating_run_enable <= 1'b1;
        burst(9'h00a);
        `CHK(lo, 8'h0a)
        for (int k = 0; k < 300 && ev.gating_interrupt !== 1'b1; k++)
            @(posedge clock);
        `CHK({ev.gating_interrupt, gt, gate}, 10'h200)
        base = lo;
        burst(9'h014);
        `CHK(lo - base <= 8'h01, 1'b1)
        lcfg.gating_run_enable <= 1'b0;
        lcfg.input_gate_select <= 1'b0;
        lcfg.lower_run_enable <= 1'b0;
        ucfg.mode <= cec_pkg::MODE_STOP;
        @(posedge clock);
        lcfg.lower_compare <= 8'h01;
        ucfg.main_compare <= 16'h0001;
        ucfg.main_toggle_enable <= 1'b1;
        ucfg.preset <= cec_pkg::PRESET_LOW;
        @(posedge clock);
        ucfg.preset <= cec_pkg::PRESET_NONE;
        ucfg.mode <= cec_pkg::MODE_CLR_MATCH;
        @(posedge clock);
        lcfg.lower_run_enable <= 1'b1;
        note(1'b0, 16'h0000);
        note(1'b0, 16'h0001);
        note(1'b1, 16'h0000);
        burst(9'h006);
        `CHK({pin, exp_q.size() == 0}, 2'h3)
        // Secondary compare rewrite just after a match, toggle parked
        ucfg.secondary_toggle_enable <= 1'b0;
        @(posedge clock);
        ucfg.secondary_compare <= 16'h0000;
        repeat (2) @(posedge clock);
        ucfg.secondary_toggle_enable <= 1'b1;
        note(1'b0, 16'h0001);
        burst(9'h002);
        `CHK({pin, exp_q.size() == 0}, 2'h1)
        stop_test();
    end
endmodule
